// File: psc_host.sv
// Serial bus host model for the bank's slave port
`include "psc_map.svh"
module psc_host (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic pull_low
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ok = 1'b1;
   logic s;
   initial begin
      scl = 1'b1;
      pull_low = 1'b0;
   end
   task automatic half();
      repeat (4) @(negedge clk);
   endtask
   // Data moves a cycle after the clock falls, never while it is high
   task automatic pulse(input logic b, output logic r);
      scl = 1'b0;
      @(negedge clk);
      pull_low = !b;
      half();
      scl = 1'b1;
      half();
      r = sda;
   endtask
   task automatic start();
      half();
      pull_low = 1'b1;
      half();
   endtask
   task automatic stop();
      scl = 1'b0;
      @(negedge clk);
      pull_low = 1'b1;
      half();
      scl = 1'b1;
      half();
      pull_low = 1'b0;
      half();
   endtask
   task automatic put(input logic [7:0] v, output logic a);
      for (int i = 7; i >= 0; i--) begin
         pulse(v[i], s);
      end
      pulse(1'b1, s);
      a = !s;
      ok &= a;
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      logic a;
      start();
      put({`PSC_SLAVE_ADDR, 1'b0}, a);
      put(p, a);
      put(d, a);
      stop();
   endtask
   // Single-byte reads only: the last byte is always refused
   task automatic rd(input logic [7:0] p, output logic [7:0] d);
      logic a;
      start();
      put({`PSC_SLAVE_ADDR, 1'b0}, a);
      put(p, a);
      stop();
      start();
      put({`PSC_SLAVE_ADDR, 1'b1}, a);
      for (int i = 7; i >= 0; i--) begin
         pulse(1'b1, d[i]);
      end
      pulse(1'b1, s);
      stop();
   endtask
endmodule

// File: psc_map.svh
// Register offsets, reset values, field positions and bus constants
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

// Register offsets
`define PSC_OFS_VERSION 8'h00
`define PSC_OFS_STATUS 8'h01
`define PSC_OFS_MASK 8'h02
`define PSC_OFS_ENABLE 8'h03
`define PSC_OFS_CONFIG 8'h04

// Reset and load values
`define PSC_RST_MASK 8'hC0
`define PSC_RST_ENABLE 8'hFF
`define PSC_RST_CONFIG 8'hB1
`define PSC_UNMAPPED 8'hFF
// Arbitrary identification value
`define PSC_VERSION_CODE 8'h5A

// Field layout of the status, mask and enable registers
`define PSC_BIT_PWRFAIL 7
`define PSC_BIT_BATLOW 6
`define PSC_SUPPLY_LSB 1
`define PSC_SUPPLY_MSB 5
`define PSC_NUM_SUPPLY 5
`define PSC_BUCK3_IDX 2
`define PSC_FLAG_MASK 8'hFE
`define PSC_ENABLE_FIXED 8'hC1

// Serial slave address and phase code for the reference converter
`define PSC_SLAVE_ADDR 7'h48
`define PSC_PHASE_ZERO 2'h0
`define PSC_BITS_PER_BYTE 4'h8

`endif

// File: psc_pkg.sv
// Types shared by the status and control register bank
package psc_pkg;

   // Phase delay code: 0, 1/4, 1/2 or 3/4 of a switching cycle
   typedef logic [1:0] psc_phase_t;

   typedef struct packed {
      psc_phase_t buck2_phase;
      psc_phase_t buck3_phase;
      logic low_ripple;
      logic buck2_forced_fixed_freq;
      logic buck1_forced_fixed_freq;
      logic buck3_forced_fixed_freq;
   } psc_cfg_t;

   typedef enum logic [6:0] {
      PSC_IDLE = 7'h01,
      PSC_ADDR = 7'h02,
      PSC_ACK_ADDR = 7'h04,
      PSC_RX_BYTE = 7'h08,
      PSC_ACK_RX = 7'h10,
      PSC_TX_BYTE = 7'h20,
      PSC_HOST_ACK = 7'h40
   } psc_state_t;

endpackage

// File: psc_regs.sv
// Power status and control register bank with its serial slave port
`include "psc_map.svh"

// Notes on behaviour
// - Offset zero reads fixed version, ignores writes
// - Offset one is read-only status, bit0 zero
// - Bits 7,6 follow fail and battery comparators
// - Supply fault bits, zero while supply disabled
// - Buck3 fault zero during core voltage move
// - Mask register at two, lockout loads C0h
// - Set mask bit keeps flag off interrupt
// - Enable register at three, resets all ones
// - Supply on equals register bit AND pin
// - Lockout reloads enable register to all ones
// - Low enable pin holds its bit at one
// - Shared linear pin resets both linear bits
// - Host writes enable bits; read returns them
// - Config register at four, lockout loads B1h
// - Config selects buck2 and buck3 phase delay
// - Buck1 always switches with zero phase
// - Config bits force fixed frequency per buck
// - Status read blocks active flags from interrupt
// - Answers only at fixed seven-bit address
// - Unmapped offsets read as all ones
module psc_regs
   import psc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic undervoltage_lockout,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic power_fail_sense_in,
   input wire logic battery_low_sense_in,
   input wire logic buck1_enable_pin,
   input wire logic buck2_enable_pin,
   input wire logic buck3_enable_pin,
   input wire logic linear_regs_enable_pin,
   input wire logic [4:0] supply_below_target,
   input wire logic dynamic_core_voltage_move,
   output logic [4:0] supply_on,
   output psc_phase_t buck1_phase,
   output psc_cfg_t converter_config,
   output logic int_n
);
   // Serial slave state
   psc_state_t state;
   psc_state_t next_state;
   logic scl_q;
   logic sda_q;
   logic [3:0] bit_cnt;
   logic [3:0] next_bit_cnt;
   logic [7:0] shreg;
   logic [7:0] next_shreg;
   logic read_dir;
   logic next_read_dir;
   logic first_byte;
   logic next_first_byte;
   logic [7:0] ptr;
   logic [7:0] next_ptr;
   logic next_sda_oe;
   logic wr_stb;
   logic next_wr_stb;
   logic [7:0] wr_data;
   logic [7:0] next_wr_data;
   logic status_rd;
   logic next_status_rd;

   // Register state
   logic [7:0] fault_irq_mask;
   logic [7:0] next_fault_irq_mask;
   psc_cfg_t next_converter_config;
   logic [7:0] irq_blocked;
   logic [7:0] next_irq_blocked;
   logic power_fail_flag;
   logic battery_low_flag;
   logic next_int_n;

   // Wires
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic [7:0] rd_data;
   logic [7:0] supply_fault_flags;
   logic [7:0] supply_enable_ctrl;
   logic [4:0] ctrl_bits;
   logic [4:0] faults;
   logic [4:0] pins;
   logic [4:0] hold_off;
   logic enable_wr;

   assign scl_rise = scl_in & ~scl_q;
   assign scl_fall = ~scl_in & scl_q;
   assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
   assign stop_cond = scl_in & scl_q & ~sda_q & sda_in;

   // Register view of status and enable bits
   assign supply_fault_flags = {power_fail_flag, battery_low_flag,
                                faults, 1'b0};
   assign supply_enable_ctrl = `PSC_ENABLE_FIXED |
                               {2'h0, ctrl_bits, 1'b0};

   always_comb begin
      case (ptr)
         `PSC_OFS_VERSION: rd_data = `PSC_VERSION_CODE;
         `PSC_OFS_STATUS: rd_data = supply_fault_flags;
         `PSC_OFS_MASK: rd_data = fault_irq_mask;
         `PSC_OFS_ENABLE: rd_data = supply_enable_ctrl;
         `PSC_OFS_CONFIG: rd_data = converter_config;
         default: rd_data = `PSC_UNMAPPED;
      endcase
   end

   // Serial slave: bits sampled on SCL rise, SDA changed after SCL fall
   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_read_dir = read_dir;
      next_first_byte = first_byte;
      next_ptr = ptr;
      next_sda_oe = sda_oe;
      next_wr_stb = 1'b0;
      next_wr_data = wr_data;
      next_status_rd = 1'b0;
      case (state)
         PSC_IDLE: begin
            next_sda_oe = 1'b0;
         end
         PSC_ADDR: begin
            if (scl_rise) begin
               next_shreg = {shreg[6:0], sda_in};
               next_bit_cnt = bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `PSC_BITS_PER_BYTE) begin
               if (shreg[7:1] == `PSC_SLAVE_ADDR) begin
                  next_read_dir = shreg[0];
                  next_sda_oe = 1'b1;
                  next_state = PSC_ACK_ADDR;
               end else begin
                  next_state = PSC_IDLE;
               end
            end
         end
         PSC_ACK_ADDR: begin
            if (scl_fall) begin
               next_bit_cnt = 4'h0;
               if (read_dir) begin
                  next_shreg = {rd_data[6:0], 1'b0};
                  next_sda_oe = ~rd_data[7];
                  next_bit_cnt = 4'h1;
                  next_status_rd = (ptr == `PSC_OFS_STATUS);
                  next_state = PSC_TX_BYTE;
               end else begin
                  next_sda_oe = 1'b0;
                  next_first_byte = 1'b1;
                  next_state = PSC_RX_BYTE;
               end
            end
         end
         PSC_RX_BYTE: begin
            if (scl_rise) begin
               next_shreg = {shreg[6:0], sda_in};
               next_bit_cnt = bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `PSC_BITS_PER_BYTE) begin
               next_sda_oe = 1'b1;
               next_state = PSC_ACK_RX;
               if (first_byte) begin
                  next_ptr = shreg;
               end else begin
                  next_wr_stb = 1'b1;
                  next_wr_data = shreg;
               end
               next_first_byte = 1'b0;
            end
         end
         PSC_ACK_RX: begin
            if (scl_fall) begin
               next_sda_oe = 1'b0;
               next_bit_cnt = 4'h0;
               next_state = PSC_RX_BYTE;
            end
         end
         PSC_TX_BYTE: begin
            if (scl_fall) begin
               if (bit_cnt == `PSC_BITS_PER_BYTE) begin
                  next_sda_oe = 1'b0;
                  next_state = PSC_HOST_ACK;
               end else begin
                  next_sda_oe = ~shreg[7];
                  next_shreg = {shreg[6:0], 1'b0};
                  next_bit_cnt = bit_cnt + 4'h1;
               end
            end
         end
         PSC_HOST_ACK: begin
            // A not-acknowledge ends the read; the slave then stays idle until the next start
            if (scl_rise && sda_in) begin
               next_state = PSC_IDLE;
            end else if (scl_fall) begin
               next_shreg = {rd_data[6:0], 1'b0};
               next_sda_oe = ~rd_data[7];
               next_bit_cnt = 4'h1;
               next_status_rd = (ptr == `PSC_OFS_STATUS);
               next_state = PSC_TX_BYTE;
            end
         end
         default: begin
            next_state = PSC_IDLE;
            next_sda_oe = 1'b0;
         end
      endcase
      if (start_cond) begin
         next_state = PSC_ADDR;
         next_bit_cnt = 4'h0;
         next_sda_oe = 1'b0;
      end else if (stop_cond) begin
         next_state = PSC_IDLE;
         next_sda_oe = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state <= PSC_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         read_dir <= 1'b0;
         first_byte <= 1'b0;
         ptr <= 8'h00;
         sda_oe <= 1'b0;
         sda_out <= 1'b0;
         wr_stb <= 1'b0;
         wr_data <= 8'h00;
         status_rd <= 1'b0;
      end else begin
         state <= next_state;
         scl_q <= scl_in;
         sda_q <= sda_in;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         read_dir <= next_read_dir;
         first_byte <= next_first_byte;
         ptr <= next_ptr;
         sda_oe <= next_sda_oe;
         // Open drain: only the enable ever moves
         sda_out <= 1'b0;
         wr_stb <= next_wr_stb;
         wr_data <= next_wr_data;
         status_rd <= next_status_rd;
      end
   end

   // Supply cells; both linear regulators share one pin
   assign pins = {buck1_enable_pin, buck2_enable_pin, buck3_enable_pin,
                  linear_regs_enable_pin, linear_regs_enable_pin};
   assign hold_off = {2'h0, dynamic_core_voltage_move, 2'h0};
   assign enable_wr = wr_stb && ptr == `PSC_OFS_ENABLE;

   genvar gi;
   generate
      for (gi = 0; gi < `PSC_NUM_SUPPLY; gi++) begin : g_supply
         psc_supply_cell u_cell (
            .clk(clk),
            .resetn(resetn),
            .undervoltage_lockout(undervoltage_lockout),
            .enable_pin(pins[gi]),
            .wr(enable_wr),
            .wbit(wr_data[gi + `PSC_SUPPLY_LSB]),
            .below_target(supply_below_target[gi]),
            .hold_off(hold_off[gi]),
            .ctrl_bit(ctrl_bits[gi]),
            .supply_on(supply_on[gi]),
            .fault(faults[gi])
         );
      end
   endgenerate

   // Mask, configuration, blocking and interrupt
   always_comb begin
      next_fault_irq_mask = fault_irq_mask;
      next_converter_config = converter_config;
      if (wr_stb && ptr == `PSC_OFS_MASK) begin
         next_fault_irq_mask = wr_data & `PSC_FLAG_MASK;
      end
      if (wr_stb && ptr == `PSC_OFS_CONFIG) begin
         next_converter_config = psc_cfg_t'(wr_data);
      end
      if (undervoltage_lockout) begin
         next_fault_irq_mask = `PSC_RST_MASK;
         next_converter_config = psc_cfg_t'(`PSC_RST_CONFIG);
      end
      // A block lasts only while its flag stays set, so a new fault refires
      next_irq_blocked = irq_blocked & supply_fault_flags;
      if (status_rd) begin
         next_irq_blocked = supply_fault_flags;
      end
      next_int_n = ~|(supply_fault_flags & ~next_fault_irq_mask &
                      ~next_irq_blocked &
                      `PSC_FLAG_MASK);
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         fault_irq_mask <= `PSC_RST_MASK;
         converter_config <= psc_cfg_t'(`PSC_RST_CONFIG);
         irq_blocked <= 8'h00;
         power_fail_flag <= 1'b0;
         battery_low_flag <= 1'b0;
         int_n <= 1'b1;
         buck1_phase <= `PSC_PHASE_ZERO;
      end else begin
         fault_irq_mask <= next_fault_irq_mask;
         converter_config <= next_converter_config;
         irq_blocked <= next_irq_blocked;
         power_fail_flag <= power_fail_sense_in;
         battery_low_flag <= battery_low_sense_in;
         int_n <= next_int_n;
         buck1_phase <= `PSC_PHASE_ZERO;
      end
   end
endmodule

// File: psc_regs_chk.sv
// Port checker for the status and control register bank
module psc_regs_chk
   import psc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic undervoltage_lockout,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic power_fail_sense_in,
   input wire logic battery_low_sense_in,
   input wire logic buck1_enable_pin,
   input wire logic buck2_enable_pin,
   input wire logic buck3_enable_pin,
   input wire logic linear_regs_enable_pin,
   input wire logic [4:0] supply_below_target,
   input wire logic dynamic_core_voltage_move,
   input wire logic [4:0] supply_on,
   input wire psc_phase_t buck1_phase,
   input wire psc_cfg_t converter_config,
   input wire logic int_n
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic quiet = !power_fail_sense_in && !battery_low_sense_in;
   wire logic [4:0] pins = {buck1_enable_pin, buck2_enable_pin,
      buck3_enable_pin, {2{linear_regs_enable_pin}}};
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!resetn);
   pin_off_a: assert property (
      !buck1_enable_pin |=> !supply_on[4])
      else $error("buck1 on with its pin low");
   lin_rearm_a: assert property (
      !linear_regs_enable_pin ##1 linear_regs_enable_pin
      |=> supply_on[1:0] == 2'h3) else $error("linear supplies not rearmed");
   lockout_on_a: assert property (
      undervoltage_lockout ##1 undervoltage_lockout
      |=> supply_on == $past(pins))
      else $error("supplies do not follow pins after lockout");
   cfg_load_a: assert property (
      undervoltage_lockout ##1 undervoltage_lockout
      |=> converter_config == 8'hB1) else $error("config not loaded");
   ref_phase_a: assert property (buck1_phase == 2'h0)
      else $error("reference converter phase not zero");
   quiet_int_a: assert property (
      (quiet && supply_below_target == 5'h00) [*4] |-> int_n)
      else $error("interrupt with no flag set");
   move_hide_a: assert property (
      (quiet && dynamic_core_voltage_move && supply_below_target == 5'h04)
      [*4] |-> int_n) else $error("buck3 flag shown during voltage move");
   off_hide_a: assert property (
      (quiet && !buck1_enable_pin && supply_below_target == 5'h10)
      [*5] |-> int_n) else $error("flag of a disabled supply shown");
   sda_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data line moved while clock high");
endmodule

// File: psc_regs_test.sv
// Self-checking bench for the power status and control register bank
`include "psc_map.svh"
module psc_regs_test;
   import psc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic lockout = 1'b0;
   logic pf = 1'b0;
   logic bl = 1'b0;
   logic move = 1'b0;
   logic [3:0] pins = 4'hF;
   logic [4:0] below = 5'h00;
   logic sda_oe, sda_out, int_n, scl, hl, a;
   logic [4:0] son;
   psc_phase_t ph1;
   psc_cfg_t cfg;
   logic [7:0] d, v, e;
   logic [31:0] seed = 32'hFA16F0D1;
   int fails = 0;
   int check_count = 0;
   int cycles = 0;
   wire logic sda = !hl && !(sda_oe && !sda_out);
   psc_regs DUT (.clk(clk), .resetn(resetn), .undervoltage_lockout(lockout),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .power_fail_sense_in(pf), .battery_low_sense_in(bl),
      .buck1_enable_pin(pins[3]), .buck2_enable_pin(pins[2]),
      .buck3_enable_pin(pins[1]), .linear_regs_enable_pin(pins[0]),
      .supply_below_target(below), .dynamic_core_voltage_move(move),
      .supply_on(son), .buck1_phase(ph1), .converter_config(cfg),
      .int_n(int_n));
   psc_host host (.clk(clk), .sda(sda), .scl(scl), .pull_low(hl));
   always #12.5 clk = ~clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // A low pin pins its enable bit at one
   function automatic logic [7:0] reg_exp(input logic [7:0] w,
      input logic [3:0] p);
      return w | 8'hC1 | {2'h0, ~p, ~p[0], 1'h0};
   endfunction
   task automatic check(input string w, input logic [7:0] s,
      input logic [7:0] x);
      check_count++;
      if (s !== x) begin
         fails++;
         $display("ERROR %s expected %h seen %h", w, x, s);
      end
   endtask
   task automatic rd_chk(input string w, input logic [7:0] p,
      input logic [7:0] x);
      host.rd(p, d);
      check(w, d, x);
   endtask
   task automatic int_chk(input logic x);
      check("int_n", {7'h0, int_n}, {7'h0, x});
   endtask
   task automatic complete_run();
      if (fails == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Ceiling well above the roughly 13k cycles the sequence needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         fails++;
         complete_run();
      end
   end
   initial begin
      repeat (20) @(negedge clk);
      resetn = 1'b1;
      repeat (4) @(negedge clk);
      rd_chk("version", 8'h00, `PSC_VERSION_CODE);
      rd_chk("mask", 8'h02, 8'hC0);
      rd_chk("enable", 8'h03, 8'hFF);
      rd_chk("config", 8'h04, 8'hB1);
      rd_chk("unmapped", 8'h07, 8'hFF);
      rd_chk("unmapped", 8'(rnd()) | 8'h08, 8'hFF);
      host.wr(8'h00, 8'hA5);
      host.wr(8'h01, 8'hFF);
      rd_chk("version", 8'h00, `PSC_VERSION_CODE);
      rd_chk("status", 8'h01, 8'h00);
      check("ack", {7'h0, host.ok}, 8'h01);
      host.start();
      host.put(8'h92, a);
      host.stop();
      check("foreign ack", {7'h0, a}, 8'h00);
      // The refused byte cleared the flag; every later byte must be acked
      host.ok = 1'b1;
      for (int i = 0; i < 4; i++) begin
         v = 8'(rnd());
         v[7:4] = {2'(i), 2'(3 - i)};
         host.wr(8'h04, v);
         rd_chk("config", 8'h04, v);
         check("config out", cfg, v);
      end
      for (int i = 0; i < 6; i++) begin
         pins = (i == 0) ? 4'hF : 4'(rnd());
         v = (i == 0) ? 8'h00 : 8'(rnd());
         e = reg_exp(v, pins);
         host.wr(8'h03, v);
         rd_chk("enable", 8'h03, e);
         e = {3'h0, e[5:1] & {pins, pins[0]}};
         check("supply_on", {3'h0, son}, e);
      end
      pins = 4'hF;
      host.wr(8'h02, 8'h00);
      lockout = 1'b1;
      repeat (2) @(negedge clk);
      lockout = 1'b0;
      rd_chk("mask", 8'h02, 8'hC0);
      rd_chk("enable", 8'h03, 8'hFF);
      rd_chk("config", 8'h04, 8'hB1);
      below = 5'h10;
      repeat (4) @(negedge clk);
      int_chk(1'b0);
      host.wr(8'h02, 8'hE0);
      int_chk(1'b1);
      host.wr(8'h02, 8'hC0);
      int_chk(1'b0);
      rd_chk("status", 8'h01, 8'h20);
      repeat (3) @(negedge clk);
      int_chk(1'b1);
      {pf, bl, move, below} = {3'h7, 5'h1F};
      repeat (4) @(negedge clk);
      int_chk(1'b0);
      rd_chk("status", 8'h01, 8'hF6);
      repeat (3) @(negedge clk);
      int_chk(1'b1);
      move = 1'b0;
      pins = 4'h7;
      repeat (6) @(negedge clk);
      int_chk(1'b0);
      rd_chk("status", 8'h01, 8'hDE);
      {pf, bl, move, below} = {3'h1, 5'h04};
      pins = 4'hF;
      repeat (8) @(negedge clk);
      {move, below} = {1'b0, 5'h10};
      pins = 4'h7;
      repeat (8) @(negedge clk);
      check("ack", {7'h0, host.ok}, 8'h01);
      complete_run();
   end
endmodule
bind psc_regs psc_regs_chk chk (.clk, .resetn, .undervoltage_lockout,
   .scl_in, .sda_in, .sda_out, .sda_oe, .power_fail_sense_in,
   .battery_low_sense_in, .buck1_enable_pin, .buck2_enable_pin,
   .buck3_enable_pin, .linear_regs_enable_pin, .supply_below_target,
   .dynamic_core_voltage_move, .supply_on, .buck1_phase,
   .converter_config, .int_n);

// File: psc_supply_cell.sv
// One supply: enable bit, effective enable and gated fault flag
`include "psc_map.svh"
module psc_supply_cell (
   input wire logic clk,
   input wire logic resetn,
   input wire logic undervoltage_lockout,
   input wire logic enable_pin,
   input wire logic wr,
   input wire logic wbit,
   input wire logic below_target,
   input wire logic hold_off,
   output logic ctrl_bit,
   output logic supply_on,
   output logic fault
);
   logic next_ctrl_bit;
   logic next_supply_on;
   logic next_fault;

   always_comb begin
      next_ctrl_bit = ctrl_bit;
      if (wr) begin
         next_ctrl_bit = wbit;
      end
      // Load and pin-low hold take priority over a host write
      if (undervoltage_lockout || !enable_pin) begin
         next_ctrl_bit = 1'b1;
      end
      next_supply_on = next_ctrl_bit & enable_pin;
      next_fault = below_target & next_supply_on & ~hold_off;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl_bit <= 1'b1;
         supply_on <= 1'b0;
         fault <= 1'b0;
      end else begin
         ctrl_bit <= next_ctrl_bit;
         supply_on <= next_supply_on;
         fault <= next_fault;
      end
   end
endmodule
